// ==== rtl/cbs_bus_seq.sv ====
// cbs_bus_seq: cycle-by-cycle bus sequencer of the processor
// assumes memory answers every strobed read within the cycle
`timescale 1ns/100ps
module cbs_bus_seq (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire cbs_pkg::cbs_group_t i_group,
  input wire logic [cbs_pkg::AW-1:0] i_opcode_addr,
  input wire logic [cbs_pkg::AW-1:0] i_index,
  input wire logic [cbs_pkg::AW-1:0] i_stack_ptr,
  input wire logic [cbs_pkg::DW-1:0] i_accum,
  input wire logic [cbs_pkg::AW-1:0] i_store_word,
  input wire logic [cbs_pkg::DW-1:0] i_new_operand,
  input wire logic i_rmw_write,
  input wire logic [cbs_pkg::DW-1:0] i_data,
  output logic [cbs_pkg::AW-1:0] o_addr,
  output logic o_valid_address_strobe,
  output logic o_rw,
  output logic [cbs_pkg::DW-1:0] o_data,
  output logic o_data_oe,
  output cbs_pkg::cbs_dkind_t o_data_kind,
  output logic [cbs_pkg::CW-1:0] o_cycle,
  output logic o_busy,
  output logic o_last,
  output logic o_done,
  output logic [cbs_pkg::AW-1:0] o_operand,
  output logic [cbs_pkg::AW-1:0] o_target
);
  cbs_pkg::cbs_state_t st_reg;
  cbs_pkg::cbs_state_t st_next;
  cbs_pkg::cbs_group_t grp_reg;
  cbs_pkg::cbs_group_t grp_next;
  logic [cbs_pkg::CW-1:0] cyc_reg;
  logic [cbs_pkg::CW-1:0] cyc_next;
  logic [cbs_pkg::AW-1:0] opc_reg;
  logic [cbs_pkg::AW-1:0] opc_next;
  logic [cbs_pkg::AW-1:0] idx_reg;
  logic [cbs_pkg::AW-1:0] idx_next;
  logic [cbs_pkg::AW-1:0] sp_reg;
  logic [cbs_pkg::AW-1:0] sp_next;
  logic [cbs_pkg::DW-1:0] ofs_reg;
  logic [cbs_pkg::DW-1:0] ofs_next;
  logic [cbs_pkg::DW-1:0] ehi_reg;
  logic [cbs_pkg::DW-1:0] ehi_next;
  logic [cbs_pkg::DW-1:0] elo_reg;
  logic [cbs_pkg::DW-1:0] elo_next;
  logic [cbs_pkg::AW-1:0] addr_reg;
  logic [cbs_pkg::AW-1:0] addr_next;
  logic vma_reg;
  logic vma_next;
  logic rw_reg;
  logic rw_next;
  logic [cbs_pkg::DW-1:0] dout_reg;
  logic [cbs_pkg::DW-1:0] dout_next;
  logic oe_reg;
  logic oe_next;
  cbs_pkg::cbs_dkind_t dk_reg;
  cbs_pkg::cbs_dkind_t dk_next;
  logic last_reg;
  logic last_next;
  logic done_reg;
  logic [cbs_pkg::AW-1:0] opnd_reg;
  logic [cbs_pkg::AW-1:0] opnd_next;

  wire run = st_reg == cbs_pkg::ST_RUN;
  wire fin = run && (cyc_reg == cbs_pkg::cbs_len(grp_reg));
  wire go = i_start && (!run || fin);
  wire step = run && !fin;
  wire act_next = st_next == cbs_pkg::ST_RUN;
  cbs_pkg::cbs_row_t row_nx;
  wire [cbs_pkg::AW-1:0] gen_addr;
  wire [cbs_pkg::AW-1:0] ret_addr = opc_next + cbs_pkg::RET_STEP;
  wire [cbs_pkg::DW-1:0] rd_byte = i_data;

  // sequencing: a new instruction may start in the last cycle of the one before
  assign st_next = go ? cbs_pkg::ST_RUN : (fin ? cbs_pkg::ST_IDLE : st_reg);
  assign grp_next = go ? i_group : grp_reg;
  assign cyc_next = go ? cbs_pkg::CYC_FIRST : (step ? cyc_reg + 4'h1 : cyc_reg);
  assign opc_next = go ? i_opcode_addr : opc_reg;
  assign idx_next = go ? i_index : idx_reg;
  assign sp_next = go ? i_stack_ptr : sp_reg;

  // bytes read this cycle feed the next address at once
  assign ofs_next = (dk_reg == cbs_pkg::D_OFS) ? rd_byte : ofs_reg;
  assign ehi_next = (dk_reg == cbs_pkg::D_AHI) ? rd_byte : ehi_reg;
  assign elo_next = (dk_reg == cbs_pkg::D_ALO) ? rd_byte : elo_reg;

  assign row_nx = cbs_pkg::cbs_row(grp_next, cyc_next);

  cbs_addr_gen cbs_addr_gen_inst (
    .i_asrc(row_nx.asrc),
    .i_opc(opc_next),
    .i_idx(idx_next),
    .i_ofs(ofs_next),
    .i_sp(sp_next),
    .i_ext({ehi_next, elo_next}),
    .o_addr(gen_addr)
  );

  function automatic logic [cbs_pkg::DW-1:0] wr_byte(cbs_pkg::cbs_dkind_t d);
    case (d)
      cbs_pkg::D_ACC: wr_byte = i_accum;
      cbs_pkg::D_WHI: wr_byte = i_store_word[cbs_pkg::AW-1:cbs_pkg::DW];
      cbs_pkg::D_WLO: wr_byte = i_store_word[cbs_pkg::DW-1:0];
      cbs_pkg::D_NEW: wr_byte = i_new_operand;
      cbs_pkg::D_RETLO: wr_byte = ret_addr[cbs_pkg::DW-1:0];
      cbs_pkg::D_RETHI: wr_byte = ret_addr[cbs_pkg::AW-1:cbs_pkg::DW];
      default: wr_byte = dout_reg;
    endcase
  endfunction : wr_byte

  assign addr_next = act_next ? gen_addr : addr_reg;
  assign vma_next = act_next && (row_nx.ins_vma ? i_rmw_write : row_nx.valid_address_strobe);
  assign rw_next = !act_next || row_nx.rw;
  assign oe_next = !rw_next;
  always_comb dout_next = wr_byte(row_nx.dk);
  assign dk_next = act_next ? row_nx.dk : cbs_pkg::D_IRR;
  assign last_next = act_next && (cyc_next == cbs_pkg::cbs_len(grp_next));

  // operand capture; a single-byte operand clears the high byte
  assign opnd_next =
    (dk_reg == cbs_pkg::D_OPHI) ? {rd_byte, opnd_reg[cbs_pkg::DW-1:0]} :
    (dk_reg == cbs_pkg::D_OPLO) ? {opnd_reg[cbs_pkg::AW-1:cbs_pkg::DW], rd_byte} :
    (dk_reg == cbs_pkg::D_OPND || dk_reg == cbs_pkg::D_CUR) ?
      {cbs_pkg::BYTE_ZERO, rd_byte} : opnd_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_reg <= cbs_pkg::ST_IDLE;
      grp_reg <= cbs_pkg::G_IMM8;
      cyc_reg <= cbs_pkg::CYC_FIRST;
      opc_reg <= cbs_pkg::ADDR_RST;
      idx_reg <= cbs_pkg::ADDR_RST;
      sp_reg <= cbs_pkg::ADDR_RST;
      ofs_reg <= cbs_pkg::BYTE_ZERO;
      ehi_reg <= cbs_pkg::BYTE_ZERO;
      elo_reg <= cbs_pkg::BYTE_ZERO;
    end else begin
      st_reg <= st_next;
      grp_reg <= grp_next;
      cyc_reg <= cyc_next;
      opc_reg <= opc_next;
      idx_reg <= idx_next;
      sp_reg <= sp_next;
      ofs_reg <= ofs_next;
      ehi_reg <= ehi_next;
      elo_reg <= elo_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      addr_reg <= cbs_pkg::ADDR_RST;
      vma_reg <= 1'b0;
      rw_reg <= 1'b1;
      dout_reg <= cbs_pkg::BYTE_ZERO;
      oe_reg <= 1'b0;
      dk_reg <= cbs_pkg::D_IRR;
      last_reg <= 1'b0;
      done_reg <= 1'b0;
      opnd_reg <= cbs_pkg::ADDR_RST;
    end else begin
      addr_reg <= addr_next;
      vma_reg <= vma_next;
      rw_reg <= rw_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      dk_reg <= dk_next;
      last_reg <= last_next;
      done_reg <= fin;
      opnd_reg <= opnd_next;
    end
  end

  assign o_addr = addr_reg;
  assign o_valid_address_strobe = vma_reg;
  assign o_rw = rw_reg;
  assign o_data = dout_reg;
  assign o_data_oe = oe_reg;
  assign o_data_kind = dk_reg;
  assign o_cycle = cyc_reg;
  assign o_busy = run;
  assign o_last = last_reg;
  assign o_done = done_reg;
  assign o_operand = opnd_reg;
  assign o_target = {ehi_reg, elo_reg};

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  function automatic logic at(cbs_pkg::cbs_group_t g, logic [cbs_pkg::CW-1:0] c);
    at = run && grp_reg == g && cyc_reg == c;
  endfunction : at

  wire [cbs_pkg::AW-1:0] ext_w = {ehi_reg, elo_reg};
  wire [cbs_pkg::AW-1:0] ixo_w = idx_reg + {cbs_pkg::BYTE_ZERO, ofs_reg};
  wire [cbs_pkg::DW-1:0] nc_lo = idx_reg[cbs_pkg::DW-1:0] + ofs_reg;

  property p_idle_quiet;
    !o_busy |-> !o_valid_address_strobe && o_rw && !o_data_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("bus not quiet while idle");

  property p_step;
    o_busy && !o_last |=> o_busy && o_cycle == $past(o_cycle) + 4'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("cycle number did not advance");

  property p_fetch;
    run && cyc_reg == cbs_pkg::CYC_FIRST |->
      o_valid_address_strobe && o_rw && o_addr == opc_reg &&
      o_data_kind == cbs_pkg::D_OPC;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("opcode fetch cycle wrong");

  property p_imm8;
    at(cbs_pkg::G_IMM8, cbs_pkg::CYC_FIRST) |=>
      o_addr == $past(o_addr) + cbs_pkg::ONE && o_rw &&
      o_data_kind == cbs_pkg::D_OPND && o_last;
  endproperty
  a_imm8: assert property (p_imm8)
    else $error("immediate byte sequence wrong");

  property p_imm16;
    at(cbs_pkg::G_IMM16, 4'h2) |->
      o_data_kind == cbs_pkg::D_OPHI && o_addr == opc_reg + cbs_pkg::ONE
      ##1 o_data_kind == cbs_pkg::D_OPLO && o_rw && o_last;
  endproperty
  a_imm16: assert property (p_imm16)
    else $error("immediate word order wrong");

  property p_ijmp;
    at(cbs_pkg::G_IJMP, 4'h3) |->
      o_addr == idx_reg && !o_valid_address_strobe
      ##1 o_addr == {idx_reg[cbs_pkg::AW-1:cbs_pkg::DW], nc_lo} && o_last;
  endproperty
  a_ijmp: assert property (p_ijmp)
    else $error("indexed jump addressing wrong");

  property p_ird8;
    at(cbs_pkg::G_IRD8, 4'h5) |->
      o_addr == ixo_w && o_valid_address_strobe && o_rw && o_last;
  endproperty
  a_ird8: assert property (p_ird8)
    else $error("indexed byte read address wrong");

  property p_ird16;
    at(cbs_pkg::G_IRD16, 4'h5) |->
      o_addr == ixo_w && o_data_kind == cbs_pkg::D_OPHI
      ##1 o_addr == $past(o_addr) + cbs_pkg::ONE && o_last &&
      o_data_kind == cbs_pkg::D_OPLO;
  endproperty
  a_ird16: assert property (p_ird16)
    else $error("indexed word read wrong");

  property p_ista;
    at(cbs_pkg::G_ISTA, 4'h3) |->
      (!o_valid_address_strobe)[*3]
      ##1 o_valid_address_strobe && !o_rw && o_data_oe && o_last;
  endproperty
  a_ista: assert property (p_ista)
    else $error("indexed store sequence wrong");

  property p_rmw;
    o_data_kind == cbs_pkg::D_NEW |->
      !o_rw && $past(o_data_kind) == cbs_pkg::D_IRR &&
      $past(o_data_kind, 2) == cbs_pkg::D_CUR && o_addr == $past(o_addr);
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("modify-write order wrong");

  property p_ist16;
    at(cbs_pkg::G_IST16, 4'h6) |->
      !o_rw && o_addr == ixo_w && o_data_kind == cbs_pkg::D_WHI
      ##1 !o_rw && o_addr == $past(o_addr) + cbs_pkg::ONE && o_last;
  endproperty
  a_ist16: assert property (p_ist16)
    else $error("indexed word store wrong");

  property p_ijsr;
    at(cbs_pkg::G_IJSR, 4'h4) |->
      o_addr == sp_reg && o_data_kind == cbs_pkg::D_RETLO && !o_rw
      ##1 o_addr == sp_reg - cbs_pkg::ONE && o_data_kind == cbs_pkg::D_RETHI
      ##1 !o_valid_address_strobe ##1 !o_valid_address_strobe
      ##1 !o_valid_address_strobe && o_last;
  endproperty
  a_ijsr: assert property (p_ijsr)
    else $error("indexed call sequence wrong");

  property p_xjmp;
    at(cbs_pkg::G_XJMP, 4'h3) |->
      o_addr == opc_reg + cbs_pkg::RET_STEP && o_valid_address_strobe &&
      o_rw && o_last;
  endproperty
  a_xjmp: assert property (p_xjmp)
    else $error("extended jump sequence wrong");

  property p_xrd8;
    at(cbs_pkg::G_XRD8, 4'h4) |->
      o_addr == ext_w && o_data_kind == cbs_pkg::D_OPND && o_last;
  endproperty
  a_xrd8: assert property (p_xrd8)
    else $error("extended byte read address wrong");

  property p_xrd16;
    at(cbs_pkg::G_XRD16, 4'h5) |->
      o_addr == ext_w + cbs_pkg::ONE && o_data_kind == cbs_pkg::D_OPLO &&
      $past(o_data_kind) == cbs_pkg::D_OPHI && o_last;
  endproperty
  a_xrd16: assert property (p_xrd16)
    else $error("extended word read wrong");

  property p_xsta;
    at(cbs_pkg::G_XSTA, 4'h4) |->
      !o_valid_address_strobe && o_rw && o_addr == ext_w
      ##1 o_valid_address_strobe && !o_rw && o_addr == $past(o_addr) &&
      o_data_kind == cbs_pkg::D_ACC;
  endproperty
  a_xsta: assert property (p_xsta)
    else $error("extended store sequence wrong");

  property p_drive;
    o_data_oe == !o_rw && (o_rw || o_data_kind != cbs_pkg::D_IRR);
  endproperty
  a_drive: assert property (p_drive)
    else $error("data drive disagrees with read/write");

  property p_c_jsr;
    at(cbs_pkg::G_IJSR, 4'h8);
  endproperty
  c_jsr: cover property (p_c_jsr);

  property p_c_rmw;
    o_data_kind == cbs_pkg::D_NEW && o_valid_address_strobe;
  endproperty
  c_rmw: cover property (p_c_rmw);

  property p_c_b2b;
    fin && i_start;
  endproperty
  c_b2b: cover property (p_c_b2b);

  property p_c_xsta;
    at(cbs_pkg::G_XSTA, 4'h5);
  endproperty
  c_xsta: cover property (p_c_xsta);
endmodule : cbs_bus_seq

// ==== rtl/cbs_pkg.sv ====
// cbs_pkg: bus-cycle table of the processor sequencer
// assumes one processor clock; each table row is one machine cycle
package cbs_pkg;
  localparam int AW = 16;
  localparam int DW = 8;
  localparam int CW = 4;
  localparam logic [CW-1:0] CYC_FIRST = 4'h1;
  localparam logic [AW-1:0] ADDR_RST = 16'h0000;
  localparam logic [AW-1:0] ONE = 16'h0001;
  localparam logic [AW-1:0] RET_STEP = 16'h0002;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} cbs_state_t;

  typedef enum logic [3:0] {
    G_IMM8, G_IMM16, G_IJMP, G_IRD8, G_IRD16, G_ISTA, G_IRMW,
    G_IST16, G_IJSR, G_XJMP, G_XRD8, G_XRD16, G_XSTA, G_XRMW
  } cbs_group_t;

  // address sources
  typedef enum logic [3:0] {
    A_OPC, A_OPC1, A_OPC2, A_IDX, A_IXNC, A_IXO, A_IXO1,
    A_SP, A_SPM1, A_SPM2, A_EXT, A_EXT1
  } cbs_asrc_t;

  // meaning of the data byte
  typedef enum logic [3:0] {
    D_OPC, D_OPND, D_OPHI, D_OPLO, D_OFS, D_IRR, D_AHI, D_ALO,
    D_RETLO, D_RETHI, D_ACC, D_WHI, D_WLO, D_CUR, D_NEW
  } cbs_dkind_t;

  typedef struct packed {
    logic valid_address_strobe;
    logic rw;
    logic ins_vma;
    cbs_asrc_t asrc;
    cbs_dkind_t dk;
  } cbs_row_t;

  function automatic cbs_row_t mk(logic v, logic w, cbs_asrc_t a, cbs_dkind_t d);
    mk = '{valid_address_strobe: v, rw: w, ins_vma: 1'b0, asrc: a, dk: d};
  endfunction : mk

  function automatic logic [CW-1:0] cbs_len(cbs_group_t g);
    case (g)
      G_IMM8: cbs_len = 4'h2;
      G_IMM16, G_XJMP: cbs_len = 4'h3;
      G_IJMP, G_XRD8: cbs_len = 4'h4;
      G_IRD8, G_XRD16, G_XSTA: cbs_len = 4'h5;
      G_IRD16, G_ISTA, G_XRMW: cbs_len = 4'h6;
      G_IRMW, G_IST16: cbs_len = 4'h7;
      G_IJSR: cbs_len = 4'h8;
      default: cbs_len = CYC_FIRST;
    endcase
  endfunction : cbs_len

  function automatic cbs_row_t cbs_row(cbs_group_t g, logic [CW-1:0] c);
    cbs_row_t r;
    logic ix;
    logic xt;
    ix = g inside {G_IJMP, G_IRD8, G_IRD16, G_ISTA, G_IRMW, G_IST16, G_IJSR};
    xt = g inside {G_XJMP, G_XRD8, G_XRD16, G_XSTA, G_XRMW};
    r = mk(1'b0, 1'b1, A_OPC, D_IRR);
    if (c == CYC_FIRST) r = mk(1'b1, 1'b1, A_OPC, D_OPC);
    else if (ix && c == 4'h2) r = mk(1'b1, 1'b1, A_OPC1, D_OFS);
    else if (ix && c == 4'h3) r = mk(1'b0, 1'b1, A_IDX, D_IRR);
    else if (ix && c == 4'h4 && g != G_IJSR) r = mk(1'b0, 1'b1, A_IXNC, D_IRR);
    else if (xt && c == 4'h2) r = mk(1'b1, 1'b1, A_OPC1, D_AHI);
    else if (xt && c == 4'h3) r = mk(1'b1, 1'b1, A_OPC2, D_ALO);
    else begin
      case ({g, c})
        {G_IMM8, 4'h2}: r = mk(1'b1, 1'b1, A_OPC1, D_OPND);
        {G_IMM16, 4'h2}: r = mk(1'b1, 1'b1, A_OPC1, D_OPHI);
        {G_IMM16, 4'h3}: r = mk(1'b1, 1'b1, A_OPC2, D_OPLO);
        {G_IRD8, 4'h5}: r = mk(1'b1, 1'b1, A_IXO, D_OPND);
        {G_IRD16, 4'h5}: r = mk(1'b1, 1'b1, A_IXO, D_OPHI);
        {G_IRD16, 4'h6}: r = mk(1'b1, 1'b1, A_IXO1, D_OPLO);
        {G_ISTA, 4'h5}: r = mk(1'b0, 1'b1, A_IXO, D_IRR);
        {G_ISTA, 4'h6}: r = mk(1'b1, 1'b0, A_IXO, D_ACC);
        {G_IRMW, 4'h5}: r = mk(1'b1, 1'b1, A_IXO, D_CUR);
        {G_IRMW, 4'h6}: r = mk(1'b0, 1'b1, A_IXO, D_IRR);
        {G_IRMW, 4'h7}: r = mk(1'b1, 1'b0, A_IXO, D_NEW);
        {G_IST16, 4'h5}: r = mk(1'b0, 1'b1, A_IXO, D_IRR);
        {G_IST16, 4'h6}: r = mk(1'b1, 1'b0, A_IXO, D_WHI);
        {G_IST16, 4'h7}: r = mk(1'b1, 1'b0, A_IXO1, D_WLO);
        {G_IJSR, 4'h4}: r = mk(1'b1, 1'b0, A_SP, D_RETLO);
        {G_IJSR, 4'h5}: r = mk(1'b1, 1'b0, A_SPM1, D_RETHI);
        {G_IJSR, 4'h6}: r = mk(1'b0, 1'b1, A_SPM2, D_IRR);
        {G_IJSR, 4'h7}: r = mk(1'b0, 1'b1, A_IDX, D_IRR);
        {G_IJSR, 4'h8}: r = mk(1'b0, 1'b1, A_IXNC, D_IRR);
        {G_XRD8, 4'h4}: r = mk(1'b1, 1'b1, A_EXT, D_OPND);
        {G_XRD16, 4'h4}: r = mk(1'b1, 1'b1, A_EXT, D_OPHI);
        {G_XRD16, 4'h5}: r = mk(1'b1, 1'b1, A_EXT1, D_OPLO);
        {G_XSTA, 4'h4}: r = mk(1'b0, 1'b1, A_EXT, D_IRR);
        {G_XSTA, 4'h5}: r = mk(1'b1, 1'b0, A_EXT, D_ACC);
        {G_XRMW, 4'h4}: r = mk(1'b1, 1'b1, A_EXT, D_CUR);
        {G_XRMW, 4'h5}: r = mk(1'b0, 1'b1, A_EXT, D_IRR);
        {G_XRMW, 4'h6}: r = mk(1'b1, 1'b0, A_EXT, D_NEW);
        default: ;
      endcase
    end
    // write-back strobe level comes from the instruction
    if (r.dk == D_NEW) r.ins_vma = 1'b1;
    return r;
  endfunction : cbs_row
endpackage : cbs_pkg

// ==== rtl/cbs_addr_gen.sv ====
// cbs_addr_gen: address bus value for one address source
// assumes operands come unlatched from the sequencer's next-state values
`timescale 1ns/100ps
module cbs_addr_gen (
  input wire cbs_pkg::cbs_asrc_t i_asrc,
  input wire logic [cbs_pkg::AW-1:0] i_opc,
  input wire logic [cbs_pkg::AW-1:0] i_idx,
  input wire logic [cbs_pkg::DW-1:0] i_ofs,
  input wire logic [cbs_pkg::AW-1:0] i_sp,
  input wire logic [cbs_pkg::AW-1:0] i_ext,
  output logic [cbs_pkg::AW-1:0] o_addr
);
  wire [cbs_pkg::DW-1:0] ofs_sum = i_idx[cbs_pkg::DW-1:0] + i_ofs;
  wire [cbs_pkg::AW-1:0] ixnc = {i_idx[cbs_pkg::AW-1:cbs_pkg::DW], ofs_sum};
  wire [cbs_pkg::AW-1:0] ixo = i_idx + {cbs_pkg::BYTE_ZERO, i_ofs};

  function automatic logic [cbs_pkg::AW-1:0] pick(cbs_pkg::cbs_asrc_t a);
    case (a)
      cbs_pkg::A_OPC1: pick = i_opc + cbs_pkg::ONE;
      cbs_pkg::A_OPC2: pick = i_opc + cbs_pkg::RET_STEP;
      cbs_pkg::A_IDX: pick = i_idx;
      cbs_pkg::A_IXNC: pick = ixnc;
      cbs_pkg::A_IXO: pick = ixo;
      cbs_pkg::A_IXO1: pick = ixo + cbs_pkg::ONE;
      cbs_pkg::A_SP: pick = i_sp;
      cbs_pkg::A_SPM1: pick = i_sp - cbs_pkg::ONE;
      cbs_pkg::A_SPM2: pick = i_sp - cbs_pkg::RET_STEP;
      cbs_pkg::A_EXT: pick = i_ext;
      cbs_pkg::A_EXT1: pick = i_ext + cbs_pkg::ONE;
      default: pick = i_opc;
    endcase
  endfunction : pick

  // a process, so any operand that pick reads re-evaluates the address
  always_comb o_addr = pick(i_asrc);
endmodule : cbs_addr_gen

// ==== testbench/cbs_mem_model.sv ====
// cbs_mem_model: memory and peripherals on the processor bus
// assumes registered bus outputs of the sequencer, one processor clock
`timescale 1ns/100ps
module cbs_mem_model (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_addr,
  input wire logic i_vma,
  input wire logic i_rw,
  output logic [7:0] o_rdata
);
  logic [7:0] last_reg = 8'h3c;
  logic rd_sel;
  // strobe-low and write cycles get no answer
  assign rd_sel = i_vma & i_rw;
  // fixed address pattern in the same cycle; released bus shows inverse of last byte
  assign o_rdata = rd_sel ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'ha5) : ~last_reg;
  always @(posedge i_clk_sys) begin
    last_reg <= o_rdata;
  end
endmodule : cbs_mem_model

// ==== testbench/cbs_bus_seq_tb.sv ====
// cbs_bus_seq_tb: self-checking bench of the bus-cycle sequencer
// assumes the memory model answers strobed reads with a fixed address pattern
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module cbs_bus_seq_tb;
  logic clk = 1'b0;
  logic rstn, start, rmw_wr, valid_address_strobe, rw, oe, busy, last, done;
  cbs_pkg::cbs_group_t grp;
  logic [15:0] opc, idx, sp, sw, addr, operand, target;
  logic [7:0] acc, nop, rdata, wdata;
  logic [3:0] cyc;
  cbs_pkg::cbs_dkind_t kind;
  wire logic [15:0] o1, o2, inc, ixo, ixo1, ext;
  wire logic [7:0] ofs;
  int n_mismatch = 0;
  int cmp_count = 0;
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction : m
  assign o1 = opc + 16'h0001;
  assign o2 = opc + 16'h0002;
  assign ofs = m(o1);
  assign inc = {idx[15:8], idx[7:0] + ofs};
  assign ixo = idx + {8'h00, ofs};
  assign ixo1 = ixo + 16'h0001;
  assign ext = {m(o1), m(o2)};
  always #5 clk = ~clk;
  cbs_bus_seq cbs_bus_seq_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_start(start),
    .i_group(grp), .i_opcode_addr(opc), .i_index(idx), .i_stack_ptr(sp), .i_accum(acc),
    .i_store_word(sw), .i_new_operand(nop), .i_rmw_write(rmw_wr), .i_data(rdata),
    .o_addr(addr), .o_valid_address_strobe(valid_address_strobe), .o_rw(rw), .o_data(wdata),
    .o_data_oe(oe), .o_data_kind(kind), .o_cycle(cyc), .o_busy(busy), .o_last(last),
    .o_done(done), .o_operand(operand), .o_target(target));
  cbs_mem_model cbs_mem_model_inst (.i_clk_sys(clk), .i_addr(addr), .i_vma(valid_address_strobe),
    .i_rw(rw), .o_rdata(rdata));
  // one bus cycle: address, strobe/read-write, write data
  task automatic b(input logic [15:0] a, input logic [1:0] vw, input logic [7:0] d);
    @(posedge clk);
    #1;
    `CHK({addr, valid_address_strobe, rw}, {a, vw})
    if (!vw[0]) `CHK({oe, wdata}, {1'b1, d})
  endtask : b
  task automatic go(input cbs_pkg::cbs_group_t g);
    start = 1'b1;
    grp = g;
    @(posedge clk);
    #1;
    start = 1'b0;
    `CHK({addr, valid_address_strobe, rw, busy, cyc, kind}, {opc, 3'b111, 4'h1, cbs_pkg::D_OPC})
  endtask : go
  task automatic fin;
    `CHK(last, 1'b1)
    @(posedge clk);
    #1;
    `CHK({done, busy}, 2'b10)
  endtask : fin
  task automatic ipre;
    b(o1, 2'b11, '0);
    b(idx, 2'b01, '0);
    b(inc, 2'b01, '0);
  endtask : ipre
  task automatic xpre;
    b(o1, 2'b11, '0);
    b(o2, 2'b11, '0);
  endtask : xpre
  task automatic t_reset;
    `CHK({valid_address_strobe, rw, oe, busy, last, done, addr}, {6'b010000, 16'h0000})
    $display("test reset done");
  endtask : t_reset
  task automatic t_imm;
    go(cbs_pkg::G_IMM8);
    b(o1, 2'b11, '0);
    go(cbs_pkg::G_IMM16);
    `CHK(operand, {8'h00, m(o1)})
    b(o1, 2'b11, '0);
    b(o2, 2'b11, '0);
    fin();
    `CHK(operand, {m(o1), m(o2)})
    $display("test immediate done");
  endtask : t_imm
  task automatic t_idx_rd;
    go(cbs_pkg::G_IJMP);
    ipre();
    go(cbs_pkg::G_IRD8);
    ipre();
    b(ixo, 2'b11, '0);
    fin();
    `CHK(operand, {8'h00, m(ixo)})
    go(cbs_pkg::G_IRD16);
    ipre();
    b(ixo, 2'b11, '0);
    b(ixo1, 2'b11, '0);
    fin();
    `CHK(operand, {m(ixo), m(ixo1)})
    $display("test indexed read done");
  endtask : t_idx_rd
  task automatic t_idx_wr;
    go(cbs_pkg::G_ISTA);
    ipre();
    b(ixo, 2'b01, '0);
    b(ixo, 2'b10, acc);
    go(cbs_pkg::G_IST16);
    ipre();
    b(ixo, 2'b01, '0);
    b(ixo, 2'b10, sw[15:8]);
    b(ixo1, 2'b10, sw[7:0]);
    go(cbs_pkg::G_IRMW);
    ipre();
    b(ixo, 2'b11, '0);
    b(ixo, 2'b01, '0);
    b(ixo, {rmw_wr, 1'b0}, nop);
    fin();
    $display("test indexed write done");
  endtask : t_idx_wr
  task automatic t_call;
    go(cbs_pkg::G_IJSR);
    b(o1, 2'b11, '0);
    b(idx, 2'b01, '0);
    b(sp, 2'b10, o2[7:0]);
    b(sp - 16'h0001, 2'b10, o2[15:8]);
    b(sp - 16'h0002, 2'b01, '0);
    b(idx, 2'b01, '0);
    b(inc, 2'b01, '0);
    fin();
    $display("test indexed call done");
  endtask : t_call
  task automatic t_ext;
    rmw_wr = 1'b0;
    go(cbs_pkg::G_XJMP);
    xpre();
    fin();
    `CHK(target, ext)
    go(cbs_pkg::G_XRD16);
    xpre();
    b(ext, 2'b11, '0);
    b(ext + 16'h0001, 2'b11, '0);
    fin();
    `CHK(operand, {m(ext), m(ext + 16'h0001)})
    go(cbs_pkg::G_XSTA);
    xpre();
    b(ext, 2'b01, '0);
    b(ext, 2'b10, acc);
    go(cbs_pkg::G_XRMW);
    xpre();
    b(ext, 2'b11, '0);
    b(ext, 2'b01, '0);
    b(ext, {rmw_wr, 1'b0}, nop);
    fin();
    $display("test extended done");
  endtask : t_ext
  // start raised mid-instruction must be ignored
  task automatic t_refuse;
    go(cbs_pkg::G_XRD8);
    b(o1, 2'b11, '0);
    start = 1'b1;
    grp = cbs_pkg::G_IMM8;
    b(o2, 2'b11, '0);
    start = 1'b0;
    b(ext, 2'b11, '0);
    fin();
    `CHK(operand, {8'h00, m(ext)})
    $display("test refused start done");
  endtask : t_refuse
  // reset in mid-instruction returns the bus to idle at the next clock edge
  task automatic t_abort;
    go(cbs_pkg::G_IRMW);
    ipre();
    rstn = 1'b0;
    @(posedge clk);
    #1;
    `CHK({valid_address_strobe, rw, oe, busy, last, done, addr}, {6'b010000, 16'h0000})
    rstn = 1'b1;
    go(cbs_pkg::G_IMM8);
    b(o1, 2'b11, '0);
    fin();
    $display("test reset abort done");
  endtask : t_abort
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    grp = cbs_pkg::G_IMM8;
    opc = 16'h20fe;
    idx = 16'h30c0;
    sp = 16'h01ff;
    sw = 16'hbeef;
    acc = 8'h3c;
    nop = 8'h96;
    rmw_wr = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_imm();
    t_idx_rd();
    t_idx_wr();
    t_call();
    t_ext();
    t_refuse();
    t_abort();
    end_sim();
  end
endmodule : cbs_bus_seq_tb
